// ==== spm_pin_mux.sv ====
// serial interface pin multiplexer for three controllers and the control port
// How it works
// - first eight pins follow nomux or isdn mode
// - tx data three-state, gci open-drain, nomux optional
// - nomux clock pins input if external clock
// - interconnect bits 14/15 float rx/tx clock
// - internal baud drives clock pins in nomux unless disabled
// - pcm sync code selects channel or idles
// - carrier change beyond one rx clock flags
// - carrier is interrupt source when not automatic
// - carrier forced asserted low in alternate use
// - clear-to-send change flags, optional frame abort
// - clear-to-send is interrupt source when unsupported
// - rts asserted while controller one has data
// - rts pin carries gci clock or request
// - baud pins inverted against clock pins
// - clock control bit 11 parks baud one high
// - port a pins individually gpio or dedicated
// - pin seven strobe two or baud two
// - multiplexed controllers two, three drive tclk
// - strobes mark b1/b2 per select and mask
// - control port enable takes three modem lines
// - pin twelve outputs baud three in nomux
`timescale 1ns/100ps
`default_nettype none
module spm_pin_mux (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire spm_pkg::spm_mode_t serial_mode_i,
  input wire logic [15:0] interconnect_ctrl_i,
  input wire logic [15:0] clock_ctrl_i,
  input wire logic [5:0] chan_map_i,
  input wire logic [1:0] strobe_channel_select_i,
  input wire logic [3:0] strobe_mask_i,
  input wire logic b1_active_i,
  input wire logic b2_active_i,
  input wire logic [1:0] l1_chan_i,
  input wire logic layer1_request_i,
  input wire logic gci_data_clock_i,
  input wire logic [2:0] brg_i,
  input wire logic [1:0] scc23_nomux_i,
  input wire logic [2:0] rx_ext_clk_i,
  input wire logic [2:0] tx_ext_clk_i,
  input wire logic [2:0] scc_txd_i,
  input wire logic [2:0] scc_tx_pending_i,
  input wire logic tx_open_drain_i,
  input wire logic cd_auto_i,
  input wire logic cts_auto_i,
  input wire logic cts_abort_en_i,
  input wire logic ctrl_port_en_i,
  input wire logic ctrl_port_tx_data_i,
  input wire logic ctrl_port_clock_i,
  input wire logic [12:0] gpio_sel_i,
  input wire logic [12:0] gpio_dir_i,
  input wire logic [12:0] gpio_out_i,
  input wire logic layer1_rx_data_i,
  input wire logic rx_clock_one_i,
  input wire logic tx_clock_one_i,
  input wire logic carrier_detect_one_n_i,
  input wire logic clear_to_send_one_n_i,
  input wire logic [12:0] port_a_i,
  input wire logic [2:0] modem3_i,
  output logic [2:0] scc_rxd_o,
  output logic [2:0] scc_rx_en_o,
  output logic [2:0] scc_rclk_o,
  output logic [2:0] scc_tclk_o,
  output logic [2:0] scc_cd_n_o,
  output logic [2:0] scc_cts_n_o,
  output logic cd_event_o,
  output logic cts_event_o,
  output logic cd_irq_o,
  output logic cts_irq_o,
  output logic tx_abort_o,
  output logic layer1_grant_o,
  output logic layer1_frame_sync_o,
  output logic ctrl_port_rx_data_o,
  output logic [12:0] gpio_in_o,
  output logic layer1_tx_data_o,
  output logic layer1_tx_data_oe_o,
  output logic rx_clock_one_o,
  output logic rx_clock_one_oe_o,
  output logic tx_clock_one_o,
  output logic tx_clock_one_oe_o,
  output logic request_to_send_one_o,
  output logic baud_clock_out_one_o,
  output logic [12:0] port_a_o,
  output logic [12:0] port_a_oe_o,
  output logic [2:0] modem3_o,
  output logic [2:0] modem3_oe_o
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [spm_pkg::S_W-1:0] sync1_ff;
  logic [spm_pkg::S_W-1:0] sync2_ff;
  logic [spm_pkg::S_W-1:0] raw;

  assign raw = {modem3_i, port_a_i, clear_to_send_one_n_i, carrier_detect_one_n_i,
                tx_clock_one_i, rx_clock_one_i, layer1_rx_data_i};

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync1_ff <= '1;
      sync2_ff <= '1;
    end
    else
    begin
      sync1_ff <= raw;
      sync2_ff <= sync1_ff;
    end
  end

  logic s_rxd, s_rclk, s_tclk, s_cd, s_cts;
  logic [12:0] s_pa;
  logic [2:0] s_m3;
  assign s_rxd = sync2_ff[spm_pkg::S_RXD];
  assign s_rclk = sync2_ff[spm_pkg::S_RCLK];
  assign s_tclk = sync2_ff[spm_pkg::S_TCLK];
  assign s_cd = sync2_ff[spm_pkg::S_CD];
  assign s_cts = sync2_ff[spm_pkg::S_CTS];
  assign s_pa = sync2_ff[spm_pkg::S_PA +: 13];
  assign s_m3 = sync2_ff[spm_pkg::S_M3 +: 3];
  assign gpio_in_o = s_pa;

  // ----------------------------------------
  // mode decode and channel routing
  // ----------------------------------------
  logic is_nomux, is_link, is_gci, is_pcm, isdn_strobe;
  assign is_nomux = serial_mode_i == spm_pkg::MODE_NOMUX;
  assign is_link = serial_mode_i == spm_pkg::MODE_LINK;
  assign is_gci = serial_mode_i == spm_pkg::MODE_GCI;
  assign is_pcm = serial_mode_i == spm_pkg::MODE_PCM;
  assign isdn_strobe = is_link || is_gci;

  logic [1:0] pcm_code, act_ch, act_scc;
  logic ch_live, mux_txd;
  assign pcm_code = {s_cd, s_tclk};
  assign act_ch = is_pcm ? pcm_code : l1_chan_i;
  assign ch_live = !is_nomux && act_ch != spm_pkg::PCM_IDLE;

  always_comb
  begin
    case (act_ch)
      2'h1: act_scc = chan_map_i[1:0];
      2'h2: act_scc = chan_map_i[3:2];
      2'h3: act_scc = chan_map_i[5:4];
      default: act_scc = 2'h0;
    endcase
  end
  assign mux_txd = (act_scc == 2'h3) ? 1'b1 : scc_txd_i[act_scc];

  // strobes during the b channels
  logic [1:0] sds;
  always_comb
  begin
    for (int n = 0; n < 2; n++)
    begin
      sds[n] = isdn_strobe && strobe_channel_select_i[n] &&
               ((strobe_mask_i[2*n] && b1_active_i) ||
                (strobe_mask_i[2*n+1] && b2_active_i));
    end
  end

  // ----------------------------------------
  // modem line change detection
  // ----------------------------------------
  logic rclk_prev_ff, tclk_prev_ff, rx_samp, tx_samp;
  logic rx_edge, tx_edge, cd_lvl, cts_lvl, cd_evt, cts_evt;
  assign rx_samp = rx_ext_clk_i[0] ? s_rclk : brg_i[0];
  assign tx_samp = tx_ext_clk_i[0] ? s_tclk : brg_i[0];
  assign rx_edge = rx_samp && !rclk_prev_ff;
  assign tx_edge = tx_samp && !tclk_prev_ff;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rclk_prev_ff <= 1'b1;
      tclk_prev_ff <= 1'b1;
    end
    else
    begin
      rclk_prev_ff <= rx_samp;
      tclk_prev_ff <= tx_samp;
    end
  end

  spm_change_filter u_cd_filt (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .level_i(s_cd),
    .samp_edge_i(rx_edge),
    .level_o(cd_lvl),
    .event_o(cd_evt)
  );

  spm_change_filter u_cts_filt (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .level_i(s_cts),
    .samp_edge_i(tx_edge),
    .level_o(cts_lvl),
    .event_o(cts_evt)
  );

  assign cd_event_o = is_nomux && cd_evt;
  assign cts_event_o = is_nomux && cts_evt;
  assign cd_irq_o = cd_event_o && !cd_auto_i;
  assign cts_irq_o = cts_event_o && !cts_auto_i;
  assign tx_abort_o = cts_event_o && cts_auto_i && cts_abort_en_i && cts_lvl;
  // the grant pin relies on being tied high when unused
  assign layer1_grant_o = isdn_strobe && s_cts;
  assign layer1_frame_sync_o = isdn_strobe && s_cd;

  // ----------------------------------------
  // controller side
  // ----------------------------------------
  logic [2:0] own_nomux, own_rxd, own_rclk, own_tclk;
  assign own_nomux = {scc23_nomux_i, is_nomux};
  assign own_rxd = {s_pa[spm_pkg::PA_RXD3], s_pa[spm_pkg::PA_RXD2], s_rxd};
  assign own_rclk = {s_pa[spm_pkg::PA_RCLK3], s_pa[spm_pkg::PA_RCLK2], s_rclk};
  assign own_tclk = {s_pa[spm_pkg::PA_TCLK3], s_pa[spm_pkg::PA_TCLK2], s_tclk};

  always_comb
  begin
    for (int k = 0; k < 3; k++)
    begin
      scc_rxd_o[k] = own_nomux[k] ? own_rxd[k] : s_rxd;
      scc_rx_en_o[k] = own_nomux[k] || (ch_live && act_scc == 2'(k));
      scc_rclk_o[k] = own_nomux[k] ? (rx_ext_clk_i[k] ? own_rclk[k] : brg_i[k]) : s_rclk;
      scc_tclk_o[k] = own_nomux[k] ? (tx_ext_clk_i[k] ? own_tclk[k] : brg_i[k]) : s_rclk;
    end
  end

  assign scc_cd_n_o[0] = is_nomux ? cd_lvl : 1'b0;
  assign scc_cts_n_o[0] = is_nomux ? cts_lvl : 1'b0;
  assign scc_cd_n_o[1] = gpio_sel_i[spm_pkg::PA_CD2] ? 1'b0 : s_pa[spm_pkg::PA_CD2];
  assign scc_cts_n_o[1] = gpio_sel_i[spm_pkg::PA_CTS2] ? 1'b0 : s_pa[spm_pkg::PA_CTS2];
  assign scc_cd_n_o[2] = ctrl_port_en_i ? 1'b0 : s_m3[2];
  assign scc_cts_n_o[2] = ctrl_port_en_i ? 1'b0 : s_m3[0];
  assign ctrl_port_rx_data_o = ctrl_port_en_i ? s_m3[0] : 1'b1;

  // ----------------------------------------
  // first pin group
  // ----------------------------------------
  logic nxt_txd, nxt_txd_oe, nxt_rclk_oe, nxt_tclk, nxt_tclk_oe, nxt_rts, nxt_baud1;
  logic clk_pins_on;
  assign clk_pins_on = is_nomux && !clock_ctrl_i[spm_pkg::CLKPIN_DIS_BIT];

  always_comb
  begin
    nxt_txd = mux_txd;
    nxt_txd_oe = ch_live;
    nxt_tclk = brg_i[0];
    nxt_tclk_oe = 1'b0;
    nxt_rts = !scc_tx_pending_i[0];
    unique case (serial_mode_i)
      spm_pkg::MODE_NOMUX:
      begin
        nxt_txd = tx_open_drain_i ? 1'b0 : scc_txd_i[0];
        nxt_txd_oe = tx_open_drain_i ? !scc_txd_i[0] : 1'b1;
        nxt_tclk_oe = clk_pins_on && !tx_ext_clk_i[0] &&
                      !interconnect_ctrl_i[spm_pkg::TCLK_TRI_BIT];
        nxt_rts = !scc_tx_pending_i[0];
      end
      spm_pkg::MODE_GCI:
      begin
        nxt_txd = 1'b0;
        nxt_txd_oe = ch_live && !mux_txd;
        nxt_tclk = sds[0];
        nxt_tclk_oe = 1'b1;
        nxt_rts = gci_data_clock_i;
      end
      spm_pkg::MODE_LINK:
      begin
        nxt_tclk = sds[0];
        nxt_tclk_oe = 1'b1;
        nxt_rts = layer1_request_i;
      end
      spm_pkg::MODE_PCM:
      begin
        nxt_tclk_oe = 1'b0;
      end
    endcase
  end

  assign nxt_rclk_oe = clk_pins_on && !rx_ext_clk_i[0] &&
                       !interconnect_ctrl_i[spm_pkg::RCLK_TRI_BIT];
  assign nxt_baud1 = clock_ctrl_i[spm_pkg::BAUD1_DIS_BIT] ? 1'b1 : !brg_i[0];

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      layer1_tx_data_o <= 1'b1;
      layer1_tx_data_oe_o <= 1'b0;
      rx_clock_one_o <= 1'b0;
      rx_clock_one_oe_o <= 1'b0;
      tx_clock_one_o <= 1'b0;
      tx_clock_one_oe_o <= 1'b0;
      request_to_send_one_o <= 1'b1;
      baud_clock_out_one_o <= 1'b1;
    end
    else
    begin
      layer1_tx_data_o <= nxt_txd;
      layer1_tx_data_oe_o <= nxt_txd_oe;
      rx_clock_one_o <= brg_i[0];
      rx_clock_one_oe_o <= nxt_rclk_oe;
      tx_clock_one_o <= nxt_tclk;
      tx_clock_one_oe_o <= nxt_tclk_oe;
      request_to_send_one_o <= nxt_rts;
      baud_clock_out_one_o <= nxt_baud1;
    end
  end

  // ----------------------------------------
  // port a and modem lines
  // ----------------------------------------
  logic [12:0] ded_o, ded_oe, nxt_pa, nxt_pa_oe;
  logic [2:0] nxt_m3, nxt_m3_oe;

  always_comb
  begin
    ded_o = '0;
    ded_oe = '0;
    ded_o[spm_pkg::PA_TXD2] = scc_txd_i[1];
    ded_oe[spm_pkg::PA_TXD2] = scc23_nomux_i[0];
    ded_o[spm_pkg::PA_RCLK2] = brg_i[1];
    ded_oe[spm_pkg::PA_RCLK2] = scc23_nomux_i[0] && !rx_ext_clk_i[1];
    ded_o[spm_pkg::PA_TCLK2] = brg_i[1];
    ded_oe[spm_pkg::PA_TCLK2] = !scc23_nomux_i[0] || !tx_ext_clk_i[1];
    ded_o[spm_pkg::PA_RTS2] = !scc_tx_pending_i[1];
    ded_oe[spm_pkg::PA_RTS2] = 1'b1;
    ded_o[spm_pkg::PA_SEVEN] = (isdn_strobe || strobe_channel_select_i != 2'h0) ?
                               sds[1] : !brg_i[1];
    ded_oe[spm_pkg::PA_SEVEN] = 1'b1;
    ded_o[spm_pkg::PA_TXD3] = scc_txd_i[2];
    ded_oe[spm_pkg::PA_TXD3] = scc23_nomux_i[1];
    ded_o[spm_pkg::PA_RCLK3] = brg_i[2];
    ded_oe[spm_pkg::PA_RCLK3] = scc23_nomux_i[1] && !rx_ext_clk_i[2];
    ded_o[spm_pkg::PA_TCLK3] = brg_i[2];
    ded_oe[spm_pkg::PA_TCLK3] = !scc23_nomux_i[1] || !tx_ext_clk_i[2];
    ded_o[spm_pkg::PA_TWELVE] = !brg_i[2];
    ded_oe[spm_pkg::PA_TWELVE] = scc23_nomux_i[1];
  end

  genvar i;
  generate
    for (i = 0; i < 13; i++)
    begin : g_pa
      assign nxt_pa[i] = gpio_sel_i[i] ? gpio_out_i[i] : ded_o[i];
      assign nxt_pa_oe[i] = gpio_sel_i[i] ? gpio_dir_i[i] : ded_oe[i];
    end
  endgenerate

  always_comb
  begin
    if (ctrl_port_en_i)
    begin
      nxt_m3 = {ctrl_port_clock_i, ctrl_port_tx_data_i, 1'b0};
      nxt_m3_oe = 3'h6;
    end
    else
    begin
      nxt_m3 = {1'b0, !scc_tx_pending_i[2], 1'b0};
      nxt_m3_oe = 3'h2;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      port_a_o <= '0;
      port_a_oe_o <= '0;
      modem3_o <= '0;
      modem3_oe_o <= '0;
    end
    else
    begin
      port_a_o <= nxt_pa;
      port_a_oe_o <= nxt_pa_oe;
      modem3_o <= nxt_m3;
      modem3_oe_o <= nxt_m3_oe;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence pcm_idle_s;
    is_pcm && pcm_code == spm_pkg::PCM_IDLE;
  endsequence

  pcm_idle_float_a: assert property (pcm_idle_s |=> !layer1_tx_data_oe_o)
    else $error("tx data driven while pcm idle");
  gci_open_drain_a: assert property (is_gci |=> !layer1_tx_data_o)
    else $error("gci tx data driven high");
  rclk_float_a: assert property (interconnect_ctrl_i[spm_pkg::RCLK_TRI_BIT]
    |=> !rx_clock_one_oe_o)
    else $error("rx clock driven while floated");
  tclk_ext_a: assert property (is_nomux && tx_ext_clk_i[0] |=> !tx_clock_one_oe_o)
    else $error("tx clock driven with external clock");
  brg_park_a: assert property (clock_ctrl_i[spm_pkg::BAUD1_DIS_BIT]
    |=> baud_clock_out_one_o)
    else $error("baud pin not high when disabled");
  brg_phase_a: assert property (rx_clock_one_oe_o
    && !$past(clock_ctrl_i[spm_pkg::BAUD1_DIS_BIT])
    |-> rx_clock_one_o != baud_clock_out_one_o)
    else $error("baud pin not inverted");
  rts_pending_a: assert property (is_nomux
    |=> request_to_send_one_o == !$past(scc_tx_pending_i[0]))
    else $error("rts does not follow pending data");
  cd_event_a: assert property (cd_event_o |-> $changed(cd_lvl) && is_nomux)
    else $error("carrier event without level change");
  cd_forced_a: assert property (!is_nomux |-> !scc_cd_n_o[0] && !cd_irq_o)
    else $error("carrier not forced in alternate mode");
  pa_twelve_a: assert property (!gpio_sel_i[spm_pkg::PA_TWELVE] && scc23_nomux_i[1]
    |=> port_a_oe_o[spm_pkg::PA_TWELVE]
    && port_a_o[spm_pkg::PA_TWELVE] == !$past(brg_i[2]))
    else $error("pin twelve lacks baud three");
  ctrl_port_a: assert property (ctrl_port_en_i |=> modem3_oe_o[1] && !modem3_oe_o[0]
    && modem3_o[1] == $past(ctrl_port_tx_data_i))
    else $error("control port lines misrouted");

endmodule
`default_nettype wire

// ==== spm_pkg.sv ====
// shared types and constants of the serial pin multiplexer
package spm_pkg;

  // serial interface modes
  typedef enum logic [1:0] {MODE_NOMUX, MODE_LINK, MODE_GCI, MODE_PCM} spm_mode_t;

  // interconnect control bits
  localparam int RCLK_TRI_BIT = 14;
  localparam int TCLK_TRI_BIT = 15;

  // clock control bits
  localparam int BAUD1_DIS_BIT = 11;
  localparam int CLKPIN_DIS_BIT = 12;

  // pcm sync code that idles the highway
  localparam logic [1:0] PCM_IDLE = 2'h0;

  // sample clock edges a modem line must differ for
  localparam logic [1:0] CHG_EDGES = 2'h2;

  // reset level of active low modem lines
  localparam logic MODEM_RST = 1'h1;

  // positions in the pin synchroniser vector
  localparam int S_RXD = 0;
  localparam int S_RCLK = 1;
  localparam int S_TCLK = 2;
  localparam int S_CD = 3;
  localparam int S_CTS = 4;
  localparam int S_PA = 5;
  localparam int S_M3 = 18;
  localparam int S_W = 21;

  // port a pin positions
  localparam int PA_RXD2 = 0;
  localparam int PA_TXD2 = 1;
  localparam int PA_RCLK2 = 2;
  localparam int PA_TCLK2 = 3;
  localparam int PA_RTS2 = 5;
  localparam int PA_CD2 = 6;
  localparam int PA_SEVEN = 7;
  localparam int PA_RXD3 = 8;
  localparam int PA_TXD3 = 9;
  localparam int PA_RCLK3 = 10;
  localparam int PA_TCLK3 = 11;
  localparam int PA_TWELVE = 12;
  localparam int PA_CTS2 = 4;

endpackage

// ==== spm_change_filter.sv ====
// modem line change filter clocked by clk_i, counting edges of a serial sample clock
`timescale 1ns/100ps
`default_nettype none
module spm_change_filter (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic level_i,
  input wire logic samp_edge_i,
  output logic level_o,
  output logic event_o
);

  logic level_ff;
  logic event_ff;
  logic [1:0] cnt_ff;

  // ----------------------------------------
  // accept a new level after it outlasts one sample clock
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      level_ff <= spm_pkg::MODEM_RST;
      event_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end
    else
    begin
      event_ff <= 1'b0;
      if (level_i == level_ff)
      begin
        cnt_ff <= 2'h0;
      end
      else if (samp_edge_i)
      begin
        if (cnt_ff + 2'h1 >= spm_pkg::CHG_EDGES)
        begin
          level_ff <= level_i;
          event_ff <= 1'b1;
          cnt_ff <= 2'h0;
        end
        else
        begin
          cnt_ff <= cnt_ff + 2'h1;
        end
      end
    end
  end

  assign level_o = level_ff;
  assign event_o = event_ff;

endmodule
`default_nettype wire

// ==== spm_line_model.sv ====
// far side line device model driving the serial interface pins
`timescale 1ns/100ps
`default_nettype none
module spm_line_model (
  input wire logic rclk_drv_i,
  input wire logic tclk_drv_i,
  input wire logic cd_drv_i,
  input wire logic grant_low_i,
  input wire logic m3_drv_i,
  input wire logic [12:0] pa_drv_i,
  input wire logic rclk_i,
  input wire logic rclk_oe_i,
  input wire logic tclk_i,
  input wire logic tclk_oe_i,
  input wire logic [12:0] pa_i,
  input wire logic [12:0] pa_oe_i,
  input wire logic [2:0] m3_i,
  input wire logic [2:0] m3_oe_i,
  output logic rclk_pin_o,
  output logic tclk_pin_o,
  output logic cd_n_pin_o,
  output logic cts_n_pin_o,
  output logic [12:0] pa_pin_o,
  output logic [2:0] m3_pin_o
);
  // clock pin levels resolved from both parties, carrier driven by the far side alone
  assign rclk_pin_o = rclk_oe_i ? rclk_i : rclk_drv_i;
  assign tclk_pin_o = tclk_oe_i ? tclk_i : tclk_drv_i;
  assign cd_n_pin_o = cd_drv_i;
  // grant line held high unless asserted
  assign cts_n_pin_o = !grant_low_i;
  assign pa_pin_o = (pa_oe_i & pa_i) | (~pa_oe_i & pa_drv_i);
  assign m3_pin_o = (m3_oe_i & m3_i) | (~m3_oe_i & {2'b11, m3_drv_i});
endmodule
`default_nettype wire

// ==== tb.sv ====
// self-checking bench of the serial pin multiplexer
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  spm_pkg::spm_mode_t serial_mode_i;
  logic [15:0] interconnect_ctrl_i, clock_ctrl_i;
  logic [5:0] chan_map_i;
  logic [1:0] strobe_channel_select_i, l1_chan_i, scc23_nomux_i;
  logic [3:0] strobe_mask_i;
  logic b1_active_i, b2_active_i, layer1_request_i, gci_data_clock_i;
  logic [2:0] brg_i, rx_ext_clk_i, tx_ext_clk_i, scc_txd_i, scc_tx_pending_i, modem3_i;
  logic tx_open_drain_i, cd_auto_i, cts_auto_i, cts_abort_en_i, ctrl_port_en_i;
  logic ctrl_port_tx_data_i, ctrl_port_clock_i, layer1_rx_data_i;
  logic rx_clock_one_i, tx_clock_one_i, carrier_detect_one_n_i, clear_to_send_one_n_i;
  logic [12:0] gpio_sel_i, gpio_dir_i, gpio_out_i, port_a_i, pa_drv;
  logic [2:0] scc_rxd_o, scc_rx_en_o, scc_rclk_o, scc_tclk_o, scc_cd_n_o, scc_cts_n_o;
  logic [2:0] modem3_o, modem3_oe_o;
  logic cd_event_o, cts_event_o, cd_irq_o, cts_irq_o, tx_abort_o, layer1_grant_o;
  logic layer1_frame_sync_o, ctrl_port_rx_data_o, layer1_tx_data_o, layer1_tx_data_oe_o;
  logic rx_clock_one_o, rx_clock_one_oe_o, tx_clock_one_o, tx_clock_one_oe_o;
  logic request_to_send_one_o, baud_clock_out_one_o;
  logic [12:0] gpio_in_o, port_a_o, port_a_oe_o;
  logic rclk_drv, tclk_drv, cd_drv, grant_low, m3_drv;
  int fail_count = 0;
  int num_checks = 0;

  spm_pin_mux i_dut (
    .clk_i, .rst_n_i, .serial_mode_i, .interconnect_ctrl_i, .clock_ctrl_i, .chan_map_i,
    .strobe_channel_select_i, .strobe_mask_i, .b1_active_i, .b2_active_i, .l1_chan_i,
    .layer1_request_i, .gci_data_clock_i, .brg_i, .scc23_nomux_i, .rx_ext_clk_i,
    .tx_ext_clk_i, .scc_txd_i, .scc_tx_pending_i, .tx_open_drain_i, .cd_auto_i,
    .cts_auto_i, .cts_abort_en_i, .ctrl_port_en_i, .ctrl_port_tx_data_i,
    .ctrl_port_clock_i, .gpio_sel_i, .gpio_dir_i, .gpio_out_i, .layer1_rx_data_i,
    .rx_clock_one_i, .tx_clock_one_i, .carrier_detect_one_n_i, .clear_to_send_one_n_i,
    .port_a_i, .modem3_i, .scc_rxd_o, .scc_rx_en_o, .scc_rclk_o, .scc_tclk_o,
    .scc_cd_n_o, .scc_cts_n_o, .cd_event_o, .cts_event_o, .cd_irq_o, .cts_irq_o,
    .tx_abort_o, .layer1_grant_o, .layer1_frame_sync_o, .ctrl_port_rx_data_o,
    .gpio_in_o, .layer1_tx_data_o, .layer1_tx_data_oe_o, .rx_clock_one_o,
    .rx_clock_one_oe_o, .tx_clock_one_o, .tx_clock_one_oe_o, .request_to_send_one_o,
    .baud_clock_out_one_o, .port_a_o, .port_a_oe_o, .modem3_o, .modem3_oe_o
  );

  spm_line_model i_line (
    .rclk_drv_i(rclk_drv), .tclk_drv_i(tclk_drv), .cd_drv_i(cd_drv),
    .grant_low_i(grant_low), .m3_drv_i(m3_drv), .pa_drv_i(pa_drv),
    .rclk_i(rx_clock_one_o), .rclk_oe_i(rx_clock_one_oe_o), .tclk_i(tx_clock_one_o),
    .tclk_oe_i(tx_clock_one_oe_o), .pa_i(port_a_o), .pa_oe_i(port_a_oe_o),
    .m3_i(modem3_o), .m3_oe_i(modem3_oe_o), .rclk_pin_o(rx_clock_one_i),
    .tclk_pin_o(tx_clock_one_i), .cd_n_pin_o(carrier_detect_one_n_i),
    .cts_n_pin_o(clear_to_send_one_n_i), .pa_pin_o(port_a_i), .m3_pin_o(modem3_i)
  );

  always #50 clk_i = ~clk_i;

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic settle;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic t_baud;
    for (int b = 0; b < 2; b++)
    begin
      @(posedge clk_i);
      brg_i[0] <= b[0];
      settle();
      chk("baud one", !brg_i[0], baud_clock_out_one_o);
      chk("rx clock", {brg_i[0], 1'b1}, {rx_clock_one_o, rx_clock_one_oe_o});
      chk("tx clock", {brg_i[0], 1'b1}, {tx_clock_one_o, tx_clock_one_oe_o});
    end
    @(posedge clk_i);
    clock_ctrl_i <= 16'h1 << spm_pkg::BAUD1_DIS_BIT;
    interconnect_ctrl_i <= 16'h1 << spm_pkg::RCLK_TRI_BIT;
    settle();
    chk("baud parked", 1'b1, baud_clock_out_one_o);
    chk("rx float", 2'b01, {rx_clock_one_oe_o, tx_clock_one_oe_o});
    @(posedge clk_i);
    interconnect_ctrl_i <= 16'h1 << spm_pkg::TCLK_TRI_BIT;
    rx_ext_clk_i <= 3'h1;
    settle();
    chk("ext and float", 2'b00, {rx_clock_one_oe_o, tx_clock_one_oe_o});
    @(posedge clk_i);
    clock_ctrl_i <= 16'h1 << spm_pkg::CLKPIN_DIS_BIT;
    interconnect_ctrl_i <= 16'h0;
    rx_ext_clk_i <= 3'h0;
    settle();
    chk("clock pins off", 2'b00, {rx_clock_one_oe_o, tx_clock_one_oe_o});
    @(posedge clk_i);
    clock_ctrl_i <= 16'h0;
    $display("test baud done");
  endtask

  task automatic t_pcm;
    int k;
    @(posedge clk_i);
    serial_mode_i <= spm_pkg::MODE_PCM;
    chan_map_i <= 6'h24;
    scc_txd_i <= 3'h5;
    for (int c = 0; c < 4; c++)
    begin
      @(posedge clk_i);
      tclk_drv <= c[0];
      cd_drv <= c[1];
      settle();
      k = c - 1;
      chk("sync pin dir", 1'b0, tx_clock_one_oe_o);
      chk("cd forced", 1'b0, scc_cd_n_o[0]);
      if (c == 0)
      begin
        chk("idle oe", 4'h0, {layer1_tx_data_oe_o, scc_rx_en_o});
      end
      else
      begin
        chk("chan rx en", 3'h1 << k, scc_rx_en_o);
        chk("chan tx", {1'b1, scc_txd_i[k]}, {layer1_tx_data_oe_o, layer1_tx_data_o});
      end
    end
    @(posedge clk_i);
    cd_drv <= 1'b1;
    $display("test pcm done");
  endtask

  task automatic t_isdn;
    @(posedge clk_i);
    serial_mode_i <= spm_pkg::MODE_GCI;
    l1_chan_i <= 2'h1;
    scc_txd_i <= 3'h0;
    gci_data_clock_i <= 1'b1;
    settle();
    chk("gci drive low", 3'b011, {layer1_tx_data_o, layer1_tx_data_oe_o, request_to_send_one_o});
    chk("gci clk in", 1'b0, rx_clock_one_oe_o);
    @(posedge clk_i);
    scc_txd_i <= 3'h7;
    gci_data_clock_i <= 1'b0;
    settle();
    chk("gci release", 2'b00, {layer1_tx_data_oe_o, request_to_send_one_o});
    @(posedge clk_i);
    serial_mode_i <= spm_pkg::MODE_LINK;
    layer1_request_i <= 1'b1;
    strobe_channel_select_i <= 2'h3;
    strobe_mask_i <= 4'h5;
    b1_active_i <= 1'b1;
    settle();
    chk("link rts", 3'h7, {request_to_send_one_o, layer1_grant_o, layer1_frame_sync_o});
    chk("strobe one", 2'b11, {tx_clock_one_o, tx_clock_one_oe_o});
    chk("strobe two", 3'h7, {port_a_o[7], port_a_oe_o[7], port_a_oe_o[3]});
    @(posedge clk_i);
    b1_active_i <= 1'b0;
    layer1_request_i <= 1'b0;
    settle();
    chk("strobes off", 3'b000, {tx_clock_one_o, port_a_o[7], request_to_send_one_o});
    @(posedge clk_i);
    strobe_channel_select_i <= 2'h0;
    $display("test isdn done");
  endtask

  task automatic t_nomux;
    @(posedge clk_i);
    serial_mode_i <= spm_pkg::MODE_NOMUX;
    scc_tx_pending_i <= 3'h1;
    tx_open_drain_i <= 1'b1;
    scc_txd_i <= 3'h0;
    scc23_nomux_i <= 2'h3;
    brg_i <= 3'h6;
    layer1_rx_data_i <= 1'b1;
    settle();
    chk("rts asserted", 1'b0, request_to_send_one_o);
    chk("od low", 2'b01, {layer1_tx_data_o, layer1_tx_data_oe_o});
    chk("rx data", 1'b1, scc_rxd_o[0]);
    chk("baud two", 2'b01, {port_a_o[7], port_a_oe_o[7]});
    chk("baud three", 2'b01, {port_a_o[12], port_a_oe_o[12]});
    @(posedge clk_i);
    scc_tx_pending_i <= 3'h0;
    scc_txd_i <= 3'h7;
    settle();
    chk("rts idle", 1'b1, request_to_send_one_o);
    chk("od release", 1'b0, layer1_tx_data_oe_o);
    $display("test nomux done");
  endtask

  task automatic t_carrier;
    int ev = 0;
    int irq = 0;
    int cev = 0;
    @(posedge clk_i);
    brg_i <= 3'h0;
    cd_auto_i <= 1'b0;
    cd_drv <= 1'b0;
    grant_low <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_i);
      brg_i[0] <= ~brg_i[0];
      repeat (2)
      begin
        @(negedge clk_i);
        ev += int'(cd_event_o === 1'b1);
        irq += int'(cd_irq_o === 1'b1);
        cev += int'(cts_irq_o === 1'b1);
      end
      if (i == 3)
      begin
        chk("one edge early", 16'h0, 16'(ev));
      end
    end
    chk("cd events", 16'h1, 16'(ev));
    chk("cd irq", 16'h1, 16'(irq));
    chk("cd level", 1'b0, scc_cd_n_o[0]);
    chk("cts irq", 16'h1, 16'(cev));
    chk("cts level", 1'b0, scc_cts_n_o[0]);
    $display("test carrier done");
  endtask

  task automatic t_port;
    @(posedge clk_i);
    gpio_sel_i <= 13'h1fff;
    gpio_dir_i <= 13'h1fff;
    gpio_out_i <= 13'h1a5a;
    ctrl_port_en_i <= 1'b1;
    ctrl_port_tx_data_i <= 1'b1;
    ctrl_port_clock_i <= 1'b1;
    m3_drv <= 1'b0;
    settle();
    chk("gpio out", 13'h1a5a, port_a_o);
    chk("gpio oe", 13'h1fff, port_a_oe_o);
    chk("gpio in", 13'h1a5a, gpio_in_o);
    chk("ctrl tx clk", 4'hf, {modem3_o[2:1], modem3_oe_o[2:1]});
    chk("ctrl rx", 1'b0, ctrl_port_rx_data_o);
    $display("test port done");
  endtask

  initial
  begin
    repeat (3000) @(posedge clk_i);
    fail_count++;
    $display("watchdog expired");
    tally_and_finish();
  end

  initial
  begin
    serial_mode_i = spm_pkg::MODE_NOMUX;
    {interconnect_ctrl_i, clock_ctrl_i, chan_map_i} = '0;
    {strobe_channel_select_i, l1_chan_i, scc23_nomux_i, strobe_mask_i} = '0;
    {b1_active_i, b2_active_i, layer1_request_i, gci_data_clock_i} = '0;
    {brg_i, rx_ext_clk_i, tx_ext_clk_i, scc_txd_i, scc_tx_pending_i} = '0;
    {tx_open_drain_i, cd_auto_i, cts_auto_i, cts_abort_en_i, ctrl_port_en_i} = '0;
    {ctrl_port_tx_data_i, ctrl_port_clock_i, layer1_rx_data_i} = '0;
    {gpio_sel_i, gpio_dir_i, gpio_out_i, pa_drv} = '0;
    {rclk_drv, tclk_drv, grant_low, m3_drv} = '0;
    cd_drv = 1'b1;
    @(negedge clk_i);
    chk("reset oe", 4'h0, {layer1_tx_data_oe_o, rx_clock_one_oe_o, tx_clock_one_oe_o, 1'b0});
    chk("reset lines", 3'h7, {layer1_tx_data_o, request_to_send_one_o, baud_clock_out_one_o});
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    $display("test reset done");
    t_baud();
    t_pcm();
    t_isdn();
    t_nomux();
    t_carrier();
    t_port();
    tally_and_finish();
  end
endmodule
`default_nettype wire
